//--- hw/clock_cfg_pkg.sv
// Constants, register layout and carrier types for the oscillator and PLL configuration block
//////////////////////////////////////////////////////////////////////////////
// Summary of operation
// - Hold a four-bit crystal code, full range
// - Codes 4-15 always valid; reset code is 0xb
// - PLL rate derives from oscillator and crystal code
// - Two-bit oscillator source field, reset 0x1
// - Bit 1 disables internal oscillator, reset 0
// - Bit 0 disables main oscillator, reset 1
// - Bits 3:2 reserved, read as zero
// - Read-only translation register at offset 0x064
// - Translation loaded at reset, follows crystal code
// - PLL rate is osc times mult over (div+1)
// - Translation bits 13:5 hold nine-bit multiplier
// - Bits 4:0 hold divider; 31:14 read zero
// - Extended override bit makes extended fields win
// - Bypass selects oscillator, else divided PLL
package clock_cfg_pkg;

  localparam logic [11:0] RUN_CFG_OFS = 12'h060;
  localparam logic [11:0] PLL_XLAT_OFS = 12'h064;
  localparam logic [11:0] EXT_CFG_OFS = 12'h070;

  // Run-mode configuration field positions
  localparam int MAIN_OFF_BIT = 0;
  localparam int INT_OFF_BIT = 1;
  localparam int OSC_SRC_LSB = 4;
  localparam int CRYSTAL_CODE_LSB = 6;
  localparam int BYPASS_BIT = 11;
  localparam int RSVD_ONE_BIT = 12;
  localparam int PWRDN_BIT = 13;
  localparam int USE_DIV_BIT = 22;
  localparam int SYS_DIV_LSB = 23;
  localparam int AUTO_GATE_BIT = 27;
  // Extended configuration field positions
  localparam int OVERRIDE_BIT = 31;
  // Translation register field positions
  localparam int MULT_LSB = 5;
  localparam int DIV_LSB = 0;

  // Reset values
  localparam logic [3:0] CRYSTAL_CODE_RST = 4'hb;
  localparam logic [1:0] OSC_SRC_RST = 2'h1;
  localparam logic INT_OFF_RST = 1'b0;
  localparam logic MAIN_OFF_RST = 1'b1;
  localparam logic BYPASS_RST = 1'b1;
  localparam logic PWRDN_RST = 1'b1;
  localparam logic RSVD_ONE_VAL = 1'b1;
  localparam logic [3:0] SYS_DIV_RST = 4'hf;
  localparam logic [5:0] SYS_DIV2_RST = 6'h0f;
  localparam logic [2:0] OSC_SRC2_RST = 3'h1;

  typedef struct packed {
    logic auto_gate;
    logic [3:0] sys_div;
    logic use_sys_div;
    logic power_down;
    logic bypass;
    logic [3:0] crystal_code;
    logic [1:0] osc_source;
    logic internal_osc_off;
    logic main_osc_off;
  } run_cfg_t;

  typedef struct packed {
    logic override;
    logic [5:0] sys_div;
    logic power_down;
    logic bypass;
    logic [2:0] osc_source;
  } ext_cfg_t;

  typedef struct packed {
    logic [8:0] mult;
    logic [4:0] div;
  } pll_xlat_t;

  // Effective clock controls driven toward the oscillators, PLL and divider
  typedef struct packed {
    logic main_osc_off;
    logic internal_osc_off;
    logic [2:0] osc_source;
    logic pll_bypass;
    logic pll_power_down;
    logic use_sys_div;
    logic [5:0] sys_div;
    logic auto_gate;
    pll_xlat_t pll;
  } clk_ctrl_t;

endpackage : clock_cfg_pkg

//--- hw/oscillator_pll_config.sv
// Run-mode oscillator selection, extended override and crystal to PLL translation registers
//
// Design decision made here: strobed register access.
`timescale 1ns/1ps
`default_nettype none
module oscillator_pll_config
  import clock_cfg_pkg::*;
#(
  parameter int ADDR_W = 12
)
(
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic [ADDR_W-1:0] addr_in,
  input wire logic [31:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [31:0] rdata_out,
  output clk_ctrl_t ctrl_out
);

  // Refused at elaboration: widths under 8 or over 32 bits, although 7 bits would carry the highest offset 0x070
  if (ADDR_W < 8 || ADDR_W > 32)
  begin : g_addr_w_check
    $error("ADDR_W must lie between 8 and 32");
  end

  typedef struct packed {
    run_cfg_t run;
    ext_cfg_t ext;
    pll_xlat_t xlat;
    logic [31:0] rdata;
    clk_ctrl_t ctrl;
  } state_t;

  state_t st_ff;
  state_t nxt_st;

  //////////////////////////////////////////////////////////////////////////////
  // Fixed table: reference kept near 1 MHz so each multiplier lands close to 400 MHz
  function automatic pll_xlat_t xlat_lookup(input logic [3:0] code);
    pll_xlat_t x;
    x = '{mult: 9'h190, div: 5'h05};
    case (code)
      4'h0: x = '{mult: 9'h190, div: 5'h00};
      4'h1: x = '{mult: 9'h1b2, div: 5'h01};
      4'h2: x = '{mult: 9'h190, div: 5'h01};
      4'h3: x = '{mult: 9'h146, div: 5'h01};
      4'h4: x = '{mult: 9'h14f, div: 5'h02};
      4'h5: x = '{mult: 9'h146, div: 5'h02};
      4'h6: x = '{mult: 9'h190, div: 5'h03};
      4'h7: x = '{mult: 9'h187, div: 5'h03};
      4'h8: x = '{mult: 9'h197, div: 5'h04};
      4'h9: x = '{mult: 9'h190, div: 5'h04};
      4'ha: x = '{mult: 9'h187, div: 5'h04};
      4'hb: x = '{mult: 9'h190, div: 5'h05};
      4'hc: x = '{mult: 9'h187, div: 5'h05};
      4'hd: x = '{mult: 9'h17c, div: 5'h06};
      4'he: x = '{mult: 9'h190, div: 5'h07};
      default: x = '{mult: 9'h187, div: 5'h07};
    endcase
    return x;
  endfunction : xlat_lookup

  function automatic logic [31:0] run_word(input run_cfg_t r);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[MAIN_OFF_BIT] = r.main_osc_off;
    w[INT_OFF_BIT] = r.internal_osc_off;
    w[OSC_SRC_LSB +: 2] = r.osc_source;
    w[CRYSTAL_CODE_LSB +: 4] = r.crystal_code;
    w[BYPASS_BIT] = r.bypass;
    w[RSVD_ONE_BIT] = RSVD_ONE_VAL;
    w[PWRDN_BIT] = r.power_down;
    w[USE_DIV_BIT] = r.use_sys_div;
    w[SYS_DIV_LSB +: 4] = r.sys_div;
    w[AUTO_GATE_BIT] = r.auto_gate;
    return w;
  endfunction : run_word

  function automatic logic [31:0] ext_word(input ext_cfg_t e);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[OVERRIDE_BIT] = e.override;
    w[SYS_DIV_LSB +: 6] = e.sys_div;
    w[PWRDN_BIT] = e.power_down;
    w[BYPASS_BIT] = e.bypass;
    w[OSC_SRC_LSB +: 3] = e.osc_source;
    return w;
  endfunction : ext_word

  // Override takes source, bypass, power-down and divider; the rest always follow the run-mode register
  function automatic clk_ctrl_t ctrl_mux(input run_cfg_t r, input ext_cfg_t e, input pll_xlat_t x);
    clk_ctrl_t c;
    c.main_osc_off = r.main_osc_off;
    c.internal_osc_off = r.internal_osc_off;
    c.use_sys_div = r.use_sys_div;
    c.auto_gate = r.auto_gate;
    // The PLL adds one to the divider itself, so the raw field is passed on
    c.pll = x;
    if (e.override)
    begin
      c.osc_source = e.osc_source;
      c.pll_bypass = e.bypass;
      c.pll_power_down = e.power_down;
      c.sys_div = e.sys_div;
    end
    else
    begin
      c.osc_source = {1'b0, r.osc_source};
      c.pll_bypass = r.bypass;
      c.pll_power_down = r.power_down;
      c.sys_div = {2'b00, r.sys_div};
    end
    return c;
  endfunction : ctrl_mux

  //////////////////////////////////////////////////////////////////////////////
  // Reset images built once, so the reset branch only ever loads constants
  localparam run_cfg_t RUN_RST = '{
    auto_gate: 1'b0,
    sys_div: SYS_DIV_RST,
    use_sys_div: 1'b0,
    power_down: PWRDN_RST,
    bypass: BYPASS_RST,
    crystal_code: CRYSTAL_CODE_RST,
    osc_source: OSC_SRC_RST,
    internal_osc_off: INT_OFF_RST,
    main_osc_off: MAIN_OFF_RST
  };
  localparam ext_cfg_t EXT_RST = '{
    override: 1'b0,
    sys_div: SYS_DIV2_RST,
    power_down: PWRDN_RST,
    bypass: BYPASS_RST,
    osc_source: OSC_SRC2_RST
  };
  // Taken from the same table as live updates, so reset and table can never disagree
  localparam pll_xlat_t XLAT_RST = xlat_lookup(CRYSTAL_CODE_RST);
  localparam clk_ctrl_t CTRL_RST = ctrl_mux(RUN_RST, EXT_RST, XLAT_RST);

  //////////////////////////////////////////////////////////////////////////////
  logic [11:0] ofs;
  assign ofs = 12'(addr_in);

  always_comb
  begin
    nxt_st = st_ff;
    nxt_st.rdata = 32'h0000_0000;

    if (wr_in)
    begin
      if (ofs == RUN_CFG_OFS)
      begin
        nxt_st.run.main_osc_off = wdata_in[MAIN_OFF_BIT];
        nxt_st.run.internal_osc_off = wdata_in[INT_OFF_BIT];
        nxt_st.run.osc_source = wdata_in[OSC_SRC_LSB +: 2];
        // Codes 0-3 are accepted; keeping them off the PLL is software's job
        nxt_st.run.crystal_code = wdata_in[CRYSTAL_CODE_LSB +: 4];
        nxt_st.run.bypass = wdata_in[BYPASS_BIT];
        nxt_st.run.power_down = wdata_in[PWRDN_BIT];
        nxt_st.run.use_sys_div = wdata_in[USE_DIV_BIT];
        nxt_st.run.sys_div = wdata_in[SYS_DIV_LSB +: 4];
        nxt_st.run.auto_gate = wdata_in[AUTO_GATE_BIT];
      end
      else if (ofs == EXT_CFG_OFS)
      begin
        nxt_st.ext.override = wdata_in[OVERRIDE_BIT];
        nxt_st.ext.sys_div = wdata_in[SYS_DIV_LSB +: 6];
        nxt_st.ext.power_down = wdata_in[PWRDN_BIT];
        nxt_st.ext.bypass = wdata_in[BYPASS_BIT];
        nxt_st.ext.osc_source = wdata_in[OSC_SRC_LSB +: 3];
      end
    end

    // Follows the code in the same cycle the code lands, so no stale pair is ever seen
    nxt_st.xlat = xlat_lookup(nxt_st.run.crystal_code);

    if (rd_in)
    begin
      if (ofs == RUN_CFG_OFS)
        nxt_st.rdata = run_word(st_ff.run);
      else if (ofs == PLL_XLAT_OFS)
        nxt_st.rdata = {18'h00000, st_ff.xlat.mult, st_ff.xlat.div};
      else if (ofs == EXT_CFG_OFS)
        nxt_st.rdata = ext_word(st_ff.ext);
      else
        nxt_st.rdata = 32'h0000_0000;
    end

    // Controls come from the new settings, so they move at the edge that takes the write
    nxt_st.ctrl = ctrl_mux(nxt_st.run, nxt_st.ext, nxt_st.xlat);
  end

  //////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      st_ff <= '{run: RUN_RST, ext: EXT_RST, xlat: XLAT_RST, rdata: 32'h0000_0000, ctrl: CTRL_RST};
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  assign rdata_out = st_ff.rdata;
  assign ctrl_out = st_ff.ctrl;

endmodule : oscillator_pll_config
`default_nettype wire

//--- testbench/oscillator_pll_config_chk.sv
// Port-level assertions for the oscillator and PLL configuration block
`timescale 1ns/1ps
`default_nettype none
module oscillator_pll_config_chk
  import clock_cfg_pkg::*;
#(
  parameter int ADDR_W = 12
)
(
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic [ADDR_W-1:0] addr_in,
  input wire logic [31:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  input wire logic [31:0] rdata_out,
  input wire clk_ctrl_t ctrl_out
);
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rst_b_in);
  logic ovr_ff;
  // The override bit reaches the ports only as rdata_out bit 31 on a read of 0x070, so it is shadowed here
  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      ovr_ff <= 1'b0;
    else if (wr_in && addr_in == 12'h070)
      ovr_ff <= wdata_in[31];
  end
  sequence s_run_wr;
    wr_in && addr_in == 12'h060;
  endsequence
  a_rd_idle: assert property (!rd_in |=> rdata_out == 32'h0)
    else $error("read data not idle");
  a_xlat_read: assert property (rd_in && addr_in == 12'h064 |=> rdata_out == {18'h0, ctrl_out.pll})
    else $error("translation read wrong");
  a_rsvd_zero: assert property (rd_in && addr_in == 12'h060 |=> rdata_out[3:2] == 2'h0 &&
    rdata_out[1:0] == {ctrl_out.internal_osc_off, ctrl_out.main_osc_off})
    else $error("run config low bits wrong");
  a_osc_off: assert property (s_run_wr |=>
    {ctrl_out.internal_osc_off, ctrl_out.main_osc_off} == $past(wdata_in[1:0]))
    else $error("oscillator disable not taken");
  a_xlat_dflt: assert property (s_run_wr ##0 wdata_in[9:6] == 4'hb |=> ctrl_out.pll == 14'h3205)
    else $error("translation for code b wrong");
  a_xlat_hold: assert property (!(wr_in && addr_in == 12'h060) |=> $stable(ctrl_out.pll))
    else $error("translation moved without write");
  a_ro_write: assert property (wr_in && addr_in == 12'h064 |=> $stable(ctrl_out))
    else $error("write to read-only place took effect");
  a_src_run: assert property (s_run_wr ##0 !ovr_ff |=>
    ctrl_out.osc_source == {1'b0, $past(wdata_in[5:4])})
    else $error("oscillator source not taken");
  a_src_ext: assert property (wr_in && addr_in == 12'h070 && wdata_in[31] |=>
    ctrl_out.osc_source == $past(wdata_in[6:4]) && ctrl_out.pll_bypass == $past(wdata_in[11]))
    else $error("override fields not taken");
endmodule : oscillator_pll_config_chk
bind oscillator_pll_config oscillator_pll_config_chk #(.ADDR_W(ADDR_W)) oscillator_pll_config_chk_inst (
  .clk_in(clk_in), .rst_b_in(rst_b_in), .addr_in(addr_in), .wdata_in(wdata_in),
  .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .ctrl_out(ctrl_out));
`default_nettype wire

//--- testbench/tb_oscillator_pll_config.sv
// Register-level tests for the oscillator and PLL configuration block
`timescale 1ns/1ps
`default_nettype none
module tb_oscillator_pll_config;
  logic clk_in = 1'b0;
  logic rst_b_in = 1'b0;
  logic [11:0] addr_in = 12'h0;
  logic [31:0] wdata_in = 32'h0;
  logic wr_in = 1'b0;
  logic rd_in = 1'b0;
  logic [31:0] rdata_out;
  clock_cfg_pkg::clk_ctrl_t ctrl_out;
  int err_total = 0;
  int tests_run = 0;
  logic [31:0] d;
  logic [8:0] mul_tab [16] = '{9'h190, 9'h1b2, 9'h190, 9'h146, 9'h14f, 9'h146, 9'h190, 9'h187,
    9'h197, 9'h190, 9'h187, 9'h190, 9'h187, 9'h17c, 9'h190, 9'h187};
  logic [4:0] div_tab [16] = '{5'h0, 5'h1, 5'h1, 5'h1, 5'h2, 5'h2, 5'h3, 5'h3,
    5'h4, 5'h4, 5'h4, 5'h5, 5'h5, 5'h6, 5'h7, 5'h7};
  oscillator_pll_config #(.ADDR_W(12)) oscillator_pll_config_inst (.clk_in(clk_in), .rst_b_in(rst_b_in),
    .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
    .ctrl_out(ctrl_out));
  initial
  begin
    forever #12.5 clk_in = ~clk_in;
  end
  //////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      err_total++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [11:0] a, input logic [31:0] v);
    @(posedge clk_in);
    addr_in <= a;
    wdata_in <= v;
    wr_in <= 1'b1;
    @(posedge clk_in);
    wr_in <= 1'b0;
  endtask : wr
  // Data stand only in the cycle after the read edge, so sample just past it
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    @(posedge clk_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge clk_in);
    rd_in <= 1'b0;
    #1;
    chk(rdata_out, e);
  endtask : rd
  task automatic close_out;
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : close_out
  //////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (6) @(posedge clk_in);
    rst_b_in <= 1'b1;
    rd(12'h060, 32'h07803ad1);
    rd(12'h064, 32'h00003205);
    rd(12'h070, 32'h07802810);
    rd(12'h100, 32'h0);
    chk(32'(ctrl_out), {2'h2, 3'h1, 3'h6, 6'h0f, 1'b0, 9'h190, 5'h05});
    $display("reset values done");
    for (int i = 0; i < 16; i++)
    begin
      // Bypass and power-down stay set, so the low codes are legal here
      d = 32'h07c03811 | {22'h0, i[3:0], 6'h0};
      wr(12'h060, d);
      rd(12'h064, {18'h0, mul_tab[i], div_tab[i]});
      rd(12'h060, d);
      chk(32'(ctrl_out.pll), {18'h0, mul_tab[i], div_tab[i]});
    end
    $display("crystal table done");
    wr(12'h060, 32'hffffffff);
    rd(12'h060, 32'h0fc03bf3);
    chk(32'(ctrl_out), {2'h3, 3'h3, 3'h7, 6'h0f, 1'b1, 9'h187, 5'h07});
    for (int s = 0; s < 4; s++)
    begin
      wr(12'h060, 32'h07c03ac0 | {26'h0, s[1:0], 2'h0, s[1:0]});
      #1;
      chk({27'h0, ctrl_out.osc_source, ctrl_out.internal_osc_off, ctrl_out.main_osc_off},
        {28'h0, s[1:0], s[1:0]});
    end
    wr(12'h064, 32'h0);
    wr(12'h100, 32'h0);
    rd(12'h064, 32'h00003205);
    rd(12'h060, 32'h07c03af3);
    $display("fields done");
    wr(12'h070, 32'h80000020);
    rd(12'h070, 32'h80000020);
    chk({28'h0, ctrl_out.osc_source, ctrl_out.pll_bypass}, 32'h4);
    chk(32'(ctrl_out), {2'h3, 3'h2, 3'h1, 6'h00, 1'b0, 9'h190, 5'h05});
    wr(12'h070, 32'h0);
    #1;
    chk({28'h0, ctrl_out.osc_source, ctrl_out.pll_bypass}, 32'h7);
    $display("override done");
    @(posedge clk_in);
    rst_b_in <= 1'b0;
    @(posedge clk_in);
    rst_b_in <= 1'b1;
    rd(12'h064, 32'h00003205);
    rd(12'h070, 32'h07802810);
    rd(12'h060, 32'h07803ad1);
    chk(32'(ctrl_out), {2'h2, 3'h1, 3'h6, 6'h0f, 1'b0, 9'h190, 5'h05});
    $display("second reset done");
    close_out();
  end
  initial
  begin
    #100000;
    err_total++;
    $display("[ERR] %0t watchdog expired", $time);
    close_out();
  end
endmodule : tb_oscillator_pll_config
`default_nettype wire
